// >>> rtl/chs_pkg.sv
// Shared constants and types for the coprocessor handshake sequencer
package chs_pkg;

    // ------------------------------------------------------------------
    // Bus cycle type encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CHS_CYC_N = 2'h0;  // Nonsequential
    localparam logic [1:0] CHS_CYC_S = 2'h1;  // Sequential
    localparam logic [1:0] CHS_CYC_I = 2'h2;  // Internal, no transfer
    localparam logic [1:0] CHS_CYC_C = 2'h3;  // Coprocessor register transfer

    // ------------------------------------------------------------------
    // Address offsets and steps
    // ------------------------------------------------------------------
    localparam logic [31:0] CHS_PC_OFFER  = 32'h0000_0008;  // Fetch during offer
    localparam logic [31:0] CHS_PC_RESUME = 32'h0000_000c;  // Fetch after the instruction
    localparam logic [31:0] CHS_WORD_STEP = 32'h0000_0004;  // Sequential word stride

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  CHS_RST_CYC  = CHS_CYC_I;     // Idle bus shows internal cycles
    localparam logic [31:0] CHS_RST_ADDR = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Instruction kinds
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CHS_OP_DATA  = 2'h0,  // cop_data_operation
        CHS_OP_LOAD  = 2'h1,  // cop_load_from_memory
        CHS_OP_STORE = 2'h2   // cop_store_to_memory
    } chs_op_e;

endpackage

// >>> rtl/chs_if.sv
// Interface joining the processor end and the coprocessor end
interface chs_if;
    import chs_pkg::*;

    logic        cop_instr_flag_n;    // Low while a coprocessor instruction is offered
    logic [1:0]  bus_cycle_type;      // Cycle type of the current cycle
    logic        opcode_or_data_flag; // 0 on opcode fetch, 1 on data cycles
    logic        bus_write;           // High on memory write cycles
    logic [31:0] bus_addr;            // Current cycle address
    chs_op_e     cop_op_kind;         // Kind of the offered instruction
    logic        cop_absent_resp;     // Coprocessor absent response
    logic        cop_busy_resp;       // Coprocessor busy response
    logic [31:0] cop_wdata;           // Word driven by the coprocessor on stores
    logic [31:0] mem_rdata;           // Word returned by memory on loads

    // Processor side of the handshake
    modport proc_mp (
        output cop_instr_flag_n, bus_cycle_type, opcode_or_data_flag, bus_write, bus_addr, cop_op_kind,
        input  cop_absent_resp, cop_busy_resp
    );

    // Coprocessor side of the handshake
    modport cop_mp (
        input  cop_instr_flag_n, bus_cycle_type, opcode_or_data_flag, bus_write, bus_addr, cop_op_kind,
        input  mem_rdata,
        output cop_absent_resp, cop_busy_resp, cop_wdata
    );
endinterface

// >>> rtl/chs_cop_end.sv
// Coprocessor end of the handshake: responses, word counting, data capture
module chs_cop_end
    import chs_pkg::*;
#(
    parameter int CNT_W = 8  // Width of the word count
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // Handshake link
    chs_if.cop_mp                 link,
    // User side: what the coprocessor will take on
    input  wire logic             arm_valid,   // Pulse: load a new acceptance plan
    input  wire chs_op_e          arm_kind,    // Instruction kind it can perform
    input  wire logic [CNT_W-1:0] arm_words,   // Words to move, one or more
    input  wire logic             can_commit,  // Level: ready to commit now
    input  wire logic [31:0]      tx_data,     // Next word to supply on stores
    // User side: results
    output logic                  rx_valid,    // Pulse: load word captured
    output logic [31:0]           rx_data,
    output logic                  tx_pull,     // Pulse: store word consumed
    output logic                  committed,   // Pulse: instruction committed
    output logic                  discarded    // Pulse: abandoned offer dropped
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic             armed, next_armed;            // Holds a plan
    chs_op_e          kind, next_kind;
    logic [CNT_W-1:0] left, next_left;              // Words still to move
    logic             xfer, next_xfer;              // In transfer cycles
    logic             offered, next_offered;        // Last cycle was an offer
    logic             absent, next_absent;
    logic             busy, next_busy;
    logic             next_rx_valid, next_tx_pull, next_committed, next_discarded;
    logic [31:0]      next_rx_data, wdata, next_wdata;
    logic             offer_now, match, reject;

    // Offer of a kind it cannot do is refused in the offer cycle itself
    assign reject    = offer_now && !xfer && !match;  // RULE_02

    assign offer_now = !link.cop_instr_flag_n;
    assign match     = armed && (link.cop_op_kind == kind);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_armed     = armed;
        next_kind      = kind;
        next_left      = left;
        next_xfer      = xfer;
        next_offered   = offer_now;
        next_rx_valid  = 1'b0;
        next_rx_data   = rx_data;
        next_tx_pull   = 1'b0;
        next_committed = 1'b0;
        next_discarded = 1'b0;
        next_wdata     = tx_data;
        if (xfer) begin
            // One word per transfer cycle at sequential rate
            if (kind == CHS_OP_LOAD) begin
                next_rx_valid = 1'b1;  // RULE_11
                next_rx_data  = link.mem_rdata;
            end else begin
                next_tx_pull = 1'b1;  // RULE_17
            end
            next_left = left - CNT_W'(1);  // RULE_12
            if (left == CNT_W'(1)) begin
                next_xfer = 1'b0;
            end
        end else if (offer_now && match && !busy) begin
            // Commit seen by the processor at this edge
            next_committed = 1'b1;
            next_armed     = 1'b0;
            next_xfer      = (kind != CHS_OP_DATA);
        end else if (offered && !offer_now && match) begin
            // Offer withdrawn while waiting: drop the request
            next_discarded = 1'b1;
            next_armed     = 1'b0;
        end else if (arm_valid) begin
            next_armed = 1'b1;
            next_kind  = arm_kind;
            next_left  = (arm_words == '0) ? CNT_W'(1) : arm_words;
        end
        // Responses for the coming cycle
        if (next_xfer) begin
            next_absent = (next_left == CNT_W'(1));  // RULE_14
            next_busy   = (next_left == CNT_W'(1));  // RULE_14
        end else if (next_armed && (!offer_now || link.cop_op_kind == next_kind)) begin
            next_absent = 1'b0;  // RULE_03
            next_busy   = !can_commit;  // RULE_01 RULE_03 RULE_09
        end else begin
            next_absent = 1'b1;  // RULE_02
            next_busy   = 1'b1;  // RULE_02
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            armed     <= 1'b0;
            kind      <= CHS_OP_DATA;
            left      <= '0;
            xfer      <= 1'b0;
            offered   <= 1'b0;
            absent    <= 1'b1;
            busy      <= 1'b1;
            rx_valid  <= 1'b0;
            rx_data   <= '0;
            tx_pull   <= 1'b0;
            committed <= 1'b0;
            discarded <= 1'b0;
            wdata     <= '0;
        end else begin
            armed     <= next_armed;
            kind      <= next_kind;
            left      <= next_left;
            xfer      <= next_xfer;
            offered   <= next_offered;
            absent    <= next_absent;
            busy      <= next_busy;
            rx_valid  <= next_rx_valid;
            rx_data   <= next_rx_data;
            tx_pull   <= next_tx_pull;
            committed <= next_committed;
            discarded <= next_discarded;
            wdata     <= next_wdata;
        end
    end

    assign link.cop_absent_resp = absent || reject;
    assign link.cop_busy_resp   = busy || reject;
    assign link.cop_wdata       = wdata;

endmodule

// >>> rtl/chs_proc_end.sv
// Processor end of the handshake: offer, busy-wait, word transfers
// Overview of operation
// RULE_01 - Coprocessor commits before dropping busy
// RULE_02 - Incapable coprocessor keeps absent and busy high
// RULE_03 - Capable but waiting: absent low, busy high
// RULE_04 - Processor busy-waits while busy stays high
// RULE_05 - Interrupt may abandon a busy-waiting instruction
// RULE_06 - Ready data operation: one N cycle
// RULE_07 - Busy-wait cycles are internal at pc+8
// RULE_08 - Offer only in the 32-bit state
// RULE_09 - Load commit only when able to accept
// RULE_10 - Write low on loads, high on stores
// RULE_11 - Load words taken every sequential cycle
// RULE_12 - Coprocessor alone sets the word count
// RULE_13 - Address formed early, base written second
// RULE_14 - Last transfer marked by absent and busy
// RULE_15 - Multi-word transfers sequential, last nonsequential
// RULE_16 - Single word: one nonsequential transfer cycle
// RULE_17 - Store data supplied every sequential cycle
// RULE_18 - Store addresses increment with write high
// RULE_19 - Instruction flag low offering, high transferring
// RULE_20 - Abandoned instruction drives no transfers
module chs_proc_end
    import chs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Handshake link
    chs_if.proc_mp           link,
    // Instruction request
    input  wire logic        req_valid,      // Pulse or level: start an instruction
    input  wire chs_op_e     req_kind,       // Data operation, load or store
    input  wire logic [31:0] req_pc,         // Address of the instruction
    input  wire logic [31:0] req_data_addr,  // First transfer address
    input  wire logic [31:0] req_base_new,   // Updated base for write-back
    input  wire logic        compressed_state, // High in the 16-bit instruction state
    input  wire logic        irq,            // Interrupt request level
    // Status
    output logic             req_ready,      // Idle, request may be made
    output logic             req_refused,    // Pulse: refused in 16-bit state
    output logic             done,           // Pulse: instruction completed
    output logic             undefined,      // Pulse: no coprocessor took it
    output logic             abandoned,      // Pulse: dropped for an interrupt
    output logic             base_wb_valid,  // Pulse: base register write-back
    output logic [31:0]      base_wb_value
);

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CHS_ST_IDLE,    // No instruction
        CHS_ST_OFFER,   // First cycle and busy-wait cycles
        CHS_ST_XFER,    // Data transfer cycles
        CHS_ST_RESUME   // Fetch at pc+12
    } chs_pst_e;

    chs_pst_e    state, next_state;
    chs_op_e     kind, next_kind;
    logic [31:0] pc, next_pc;              // Instruction address
    logic [31:0] base_new, next_base_new;  // Base held for write-back
    logic [31:0] addr, next_addr;
    logic        instr_n, next_instr_n;
    logic        opflag, next_opflag;
    logic        wr, next_wr;
    logic        first_xfer, next_first_xfer;
    logic [31:0] req_data_addr_q, next_req_data_addr_q;  // Data address held until busy falls
    logic        next_req_refused, next_done, next_undefined, next_abandoned;
    logic        next_base_wb_valid;
    logic [31:0] next_base_wb_value;
    logic        resp_a, resp_b, last;

    assign resp_a = link.cop_absent_resp;
    assign resp_b = link.cop_busy_resp;
    assign last   = resp_a && resp_b;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state         = state;
        next_kind          = kind;
        next_pc            = pc;
        next_base_new      = base_new;
        next_addr          = addr;
        next_instr_n       = 1'b1;
        next_opflag        = opflag;
        next_wr            = 1'b0;
        next_first_xfer    = 1'b0;
        next_req_data_addr_q = req_data_addr_q;
        next_req_refused   = 1'b0;
        next_done          = 1'b0;
        next_undefined     = 1'b0;
        next_abandoned     = 1'b0;
        next_base_wb_valid = 1'b0;
        next_base_wb_value = base_wb_value;
        unique case (state)
            CHS_ST_IDLE: begin
                if (req_valid && compressed_state) begin
                    next_req_refused = 1'b1;  // RULE_08
                end else if (req_valid) begin
                    // First cycle: fetch at pc+8, opcode, flag low
                    next_state    = CHS_ST_OFFER;
                    next_kind     = req_kind;
                    next_pc       = req_pc;
                    next_base_new = req_base_new;
                    next_req_data_addr_q = req_data_addr;
                    next_addr     = req_pc + CHS_PC_OFFER;  // RULE_06 RULE_13
                    next_instr_n  = 1'b0;  // RULE_19
                    next_opflag   = 1'b0;  // RULE_06
                end
            end
            CHS_ST_OFFER: begin
                if (last) begin
                    // Nobody can take it: undefined trap
                    next_undefined = 1'b1;  // RULE_02
                    next_state     = CHS_ST_IDLE;
                end else if (resp_b && irq) begin
                    // Abandon with no transfer cycles
                    next_abandoned = 1'b1;  // RULE_05 RULE_20
                    next_state     = CHS_ST_IDLE;
                end else if (resp_b) begin
                    // Stay on pc+8, data flag after the first cycle
                    next_instr_n = 1'b0;  // RULE_04 RULE_19
                    next_opflag  = 1'b1;  // RULE_07
                end else if (kind == CHS_OP_DATA) begin
                    next_done      = 1'b1;  // RULE_06
                    next_state     = CHS_ST_RESUME;
                    next_addr      = pc + CHS_PC_RESUME;  // RULE_06
                    next_opflag    = 1'b0;
                end else begin
                    next_state      = CHS_ST_XFER;
                    next_addr       = req_data_addr_q;  // RULE_13
                    next_opflag     = 1'b1;  // RULE_16
                    next_wr         = (kind == CHS_OP_STORE);  // RULE_10 RULE_18
                    next_first_xfer = 1'b1;
                end
            end
            CHS_ST_XFER: begin
                if (first_xfer) begin
                    next_base_wb_valid = 1'b1;  // RULE_13
                    next_base_wb_value = base_new;
                end
                if (last) begin
                    // Coprocessor marked the final word
                    next_done      = 1'b1;  // RULE_12 RULE_14
                    next_state     = CHS_ST_RESUME;
                    next_addr      = pc + CHS_PC_RESUME;  // RULE_15
                    next_opflag    = 1'b0;
                end else begin
                    next_addr = addr + CHS_WORD_STEP;  // RULE_11 RULE_15 RULE_18
                    next_wr   = (kind == CHS_OP_STORE);  // RULE_10 RULE_18
                end
            end
            CHS_ST_RESUME: begin
                next_state  = CHS_ST_IDLE;
                next_opflag = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state           <= CHS_ST_IDLE;
            kind            <= CHS_OP_DATA;
            pc              <= CHS_RST_ADDR;
            base_new        <= CHS_RST_ADDR;
            req_data_addr_q <= CHS_RST_ADDR;
            addr            <= CHS_RST_ADDR;
            instr_n         <= 1'b1;
            opflag          <= 1'b0;
            wr              <= 1'b0;
            first_xfer      <= 1'b0;
            req_ready       <= 1'b1;
            req_refused     <= 1'b0;
            done            <= 1'b0;
            undefined       <= 1'b0;
            abandoned       <= 1'b0;
            base_wb_valid   <= 1'b0;
            base_wb_value   <= CHS_RST_ADDR;
        end else begin
            state           <= next_state;
            kind            <= next_kind;
            pc              <= next_pc;
            base_new        <= next_base_new;
            req_data_addr_q <= next_req_data_addr_q;
            addr            <= next_addr;
            instr_n         <= next_instr_n;
            opflag          <= next_opflag;
            wr              <= next_wr;
            first_xfer      <= next_first_xfer;
            req_ready       <= (next_state == CHS_ST_IDLE);
            req_refused     <= next_req_refused;
            done            <= next_done;
            undefined       <= next_undefined;
            abandoned       <= next_abandoned;
            base_wb_valid   <= next_base_wb_valid;
            base_wb_value   <= next_base_wb_value;
        end
    end

    // ----------------
    // Cycle type: follows same-cycle responses; these come from
    // flops on both ends, so no combinational loop arises
    // ----------------
    logic [1:0] cyc;
    always_comb begin
        unique case (state)
            CHS_ST_OFFER:  cyc = resp_b ? CHS_CYC_I : CHS_CYC_N;  // RULE_06 RULE_07
            CHS_ST_XFER:   cyc = last ? CHS_CYC_N : CHS_CYC_S;    // RULE_15 RULE_16
            CHS_ST_RESUME: cyc = CHS_CYC_S;
            default:       cyc = CHS_RST_CYC;
        endcase
    end

    assign link.bus_cycle_type      = cyc;
    assign link.cop_instr_flag_n    = instr_n;
    assign link.opcode_or_data_flag = opflag;
    assign link.bus_write           = wr;
    assign link.bus_addr            = addr;
    assign link.cop_op_kind         = kind;

endmodule

// >>> tb/chs_sva.sv
// Assertion checker watching the handshake link between both ends
module chs_sva
    import chs_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // Link signals
    input wire logic        cop_instr_flag_n,
    input wire logic [1:0]  bus_cycle_type,
    input wire logic        opcode_or_data_flag,
    input wire logic        bus_write,
    input wire logic [31:0] bus_addr,
    input wire chs_op_e     cop_op_kind,
    input wire logic        cop_absent_resp,
    input wire logic        cop_busy_resp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ----------------
    // Helper terms
    // ----------------
    logic off;  // Instruction on offer
    logic wt;   // Offer waiting on a busy coprocessor
    logic ok;   // Offer accepted this cycle
    logic xf;   // Transfer cycle of a load or store
    assign off = !cop_instr_flag_n;
    assign wt  = off && cop_busy_resp && !cop_absent_resp;
    assign ok  = off && !cop_busy_resp && !cop_absent_resp;
    assign xf  = cop_instr_flag_n && cop_op_kind != CHS_OP_DATA;
    // ----------------
    // Properties
    // ----------------
    a_wait_internal: assert property (wt |-> bus_cycle_type == CHS_CYC_I)
        else $error("busy-wait cycle not internal");
    a_wait_holds: assert property (off && $past(off) |-> $stable(bus_addr) && opcode_or_data_flag)
        else $error("busy-wait address or flag moved");
    a_no_early_xfer: assert property (wt |=> !bus_write && bus_cycle_type != CHS_CYC_S)
        else $error("transfer while busy");
    a_commit_nonseq: assert property (ok |-> bus_cycle_type == CHS_CYC_N)
        else $error("commit cycle not nonsequential");
    a_flag_rises: assert property (ok |=> cop_instr_flag_n)
        else $error("flag low after commit");
    a_offer_opcode: assert property ($fell(cop_instr_flag_n) |-> !opcode_or_data_flag && !bus_write)
        else $error("offer cycle flags wrong");
    a_write_store: assert property (bus_write |-> cop_instr_flag_n && cop_op_kind == CHS_OP_STORE)
        else $error("write outside store transfer");
    a_addr_step: assert property (xf && bus_cycle_type == CHS_CYC_S && !cop_busy_resp && !cop_absent_resp
        |=> bus_addr == $past(bus_addr) + CHS_WORD_STEP)
        else $error("transfer address did not step");
    a_last_nonseq: assert property (xf && opcode_or_data_flag && cop_absent_resp && cop_busy_resp
        && $past(!cop_busy_resp) |-> bus_cycle_type == CHS_CYC_N)
        else $error("last transfer not nonsequential");
    // Main scenarios reached
    c_wait: cover property (wt ##1 ok);
    c_burst: cover property (xf && bus_cycle_type == CHS_CYC_S);
    c_store: cover property (bus_write);
endmodule

// >>> tb/test_coprocessor_handshake_sequencer.sv
// Self-checking bench joining the processor and coprocessor ends
module test_coprocessor_handshake_sequencer
    import chs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // Stimulus, results and model state
    // ----------------
    logic        clk_sys, arst_n, req_valid, compressed_state, irq, arm_valid, can_commit;
    chs_op_e     req_kind, arm_kind;
    logic [31:0] req_pc, req_data_addr, req_base_new, tx_data, rx_data, base_wb_value, seed;
    logic [7:0]  arm_words;
    logic        req_ready, req_refused, done, undefined, abandoned, base_wb_valid;
    logic        rx_valid, tx_pull, committed, discarded;
    int          n_fail, checks_done, c_done, c_und, c_ab, c_disc, c_wb, c_ref;
    logic [31:0] exp_q[$], got_q[$];  // Model and captured load words
    chs_if lnk();
    // Memory image is a fixed function of the address
    assign lnk.mem_rdata = lnk.bus_addr ^ 32'h3c3c_a5a5;
    chs_proc_end i_chs_proc_end(.clk_sys, .arst_n, .link(lnk), .req_valid, .req_kind, .req_pc, .req_data_addr,
        .req_base_new, .compressed_state, .irq, .req_ready, .req_refused, .done, .undefined, .abandoned,
        .base_wb_valid, .base_wb_value);
    chs_cop_end i_chs_cop_end(.clk_sys, .arst_n, .link(lnk), .arm_valid, .arm_kind, .arm_words, .can_commit,
        .tx_data, .rx_valid, .rx_data, .tx_pull, .committed, .discarded);
    chs_sva i_chs_sva(.clk_sys, .arst_n, .cop_instr_flag_n(lnk.cop_instr_flag_n),
        .bus_cycle_type(lnk.bus_cycle_type), .opcode_or_data_flag(lnk.opcode_or_data_flag),
        .bus_write(lnk.bus_write), .bus_addr(lnk.bus_addr), .cop_op_kind(lnk.cop_op_kind),
        .cop_absent_resp(lnk.cop_absent_resp), .cop_busy_resp(lnk.cop_busy_resp));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input bit ok, input string m);
        checks_done++;
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Inputs move a fixed 1 ns after the edge
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic final_report;
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Pulse counters; pulses last one cycle so each edge sees one
    always @(posedge clk_sys) begin
        if (done) c_done++;
        if (undefined) c_und++;
        if (abandoned) c_ab++;
        if (discarded) c_disc++;
        if (req_refused) c_ref++;
        if (rx_valid) got_q.push_back(rx_data);
        if (base_wb_valid) begin
            c_wb++;
            check(base_wb_value === req_base_new, "base value");
        end
    end
    // ----------------
    // One instruction: k offered, ak armed, m words, w waits, ab abandons
    // ----------------
    task automatic run(input chs_op_e k, input chs_op_e ak, input int m, input int w, input bit ab);
        int n, d0, u0, a0, s0, w0;
        logic [31:0] pc, da;
        seed = lfsr(seed);
        pc = {seed[31:2], 2'h0};
        seed = lfsr(seed);
        da = {seed[31:2], 2'h0};
        seed = lfsr(seed);
        req_base_new = seed;
        tx_data = ~seed;
        arm_valid = 1'b1;
        arm_kind = ak;
        arm_words = m[7:0];
        can_commit = (w == 0);
        step;
        arm_valid = 1'b0;
        repeat (2) step;
        {d0, u0, a0, s0, w0} = {c_done, c_und, c_ab, c_disc, c_wb};
        req_valid = 1'b1;
        req_kind = k;
        req_pc = pc;
        req_data_addr = da;
        step;
        req_valid = 1'b0;
        n = 0;
        while (lnk.cop_instr_flag_n === 1'b0 && n < 40) begin
            check(lnk.bus_addr === pc + CHS_PC_OFFER && lnk.opcode_or_data_flag === (n != 0), "offer");
            if (ab && n == 2) irq = 1'b1;
            else if (!ab && n >= w) can_commit = 1'b1;
            step;
            n++;
        end
        irq = 1'b0;
        check(n > 0 && n <= w + 3, "offer length");
        if (ab || ak != k) begin
            repeat (3) step;
            check(c_ab - a0 == ab && c_und - u0 == (ak != k) && c_wb == w0 && (!ab || c_disc - s0 == 1), "drop");
            return;
        end
        for (int i = 0; i < m; i++) begin
            check(lnk.cop_instr_flag_n === 1'b1 && lnk.bus_addr === da + CHS_WORD_STEP * i
                && lnk.bus_write === (k == CHS_OP_STORE) && lnk.opcode_or_data_flag === 1'b1
                && lnk.bus_cycle_type === (i == m - 1 ? CHS_CYC_N : CHS_CYC_S), "transfer");
            if (k == CHS_OP_LOAD) exp_q.push_back((da + CHS_WORD_STEP * i) ^ 32'h3c3c_a5a5);
            if (k == CHS_OP_STORE) check(lnk.cop_wdata === tx_data, "store word");
            step;
        end
        check(lnk.bus_addr === pc + CHS_PC_RESUME && lnk.cop_instr_flag_n === 1'b1, "resume");
        repeat (2) step;
        check(c_done - d0 == 1 && c_wb - w0 == (k != CHS_OP_DATA), "completion");
    endtask
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        seed = 32'h4fca7fe8;
        {arst_n, req_valid, compressed_state, irq, arm_valid, can_commit} = 6'h0;
        {req_pc, req_data_addr, req_base_new, tx_data, arm_words} = '0;
        req_kind = CHS_OP_DATA;
        arm_kind = CHS_OP_DATA;
        {n_fail, checks_done, c_done, c_und, c_ab, c_disc, c_wb, c_ref} = '0;
        repeat (6) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        check(req_ready === 1'b1 && lnk.cop_instr_flag_n === 1'b1, "reset state");
        run(CHS_OP_DATA, CHS_OP_DATA, 0, 0, 0);
        run(CHS_OP_DATA, CHS_OP_DATA, 0, 3, 0);
        run(CHS_OP_LOAD, CHS_OP_LOAD, 1, 0, 0);
        run(CHS_OP_STORE, CHS_OP_STORE, 1, 2, 0);
        for (int j = 0; j < 6; j++) begin
            seed = lfsr(seed);
            run(j[0] ? CHS_OP_STORE : CHS_OP_LOAD, j[0] ? CHS_OP_STORE : CHS_OP_LOAD,
                2 + int'(seed[1:0]), int'(seed[3:2]), 0);
        end
        run(CHS_OP_LOAD, CHS_OP_LOAD, 2, 5, 1);
        run(CHS_OP_STORE, CHS_OP_LOAD, 1, 0, 0);
        // Compressed state offers nothing
        compressed_state = 1'b1;
        req_valid = 1'b1;
        step;
        req_valid = 1'b0;
        repeat (2) step;
        check(c_ref == 1 && lnk.cop_instr_flag_n === 1'b1, "refused");
        compressed_state = 1'b0;
        check(exp_q.size() == got_q.size(), "load word count");
        foreach (exp_q[i]) check(i < got_q.size() && exp_q[i] === got_q[i], "load word");
        final_report;
    end
    // Guard against a hang
    initial begin
        #500000;
        n_fail++;
        final_report;
    end
endmodule
